/* hdl/psw_pkg.sv */
// Constants and types shared by the power save and wake-up controller
package psw_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PIN_N  = 8;
    localparam int unsigned TIMER_W = 16;

    // Register offsets on the plain register port
    localparam logic [2:0] REG_CTRL      = 3'h0;
    localparam logic [2:0] REG_WAKE_EN   = 3'h1;
    localparam logic [2:0] REG_WAKE_EDGE = 3'h2;
    localparam logic [2:0] REG_WAKE_PEND = 3'h3;
    localparam logic [2:0] REG_STATUS    = 3'h4;
    localparam logic [2:0] REG_TIMER_LO  = 3'h5;
    localparam logic [2:0] REG_TIMER_HI  = 3'h6;

    // Control register bit positions
    localparam int unsigned CTRL_HALT  = 0;
    localparam int unsigned CTRL_IDLE  = 1;
    localparam int unsigned CTRL_IDLE_TIMER_IRQ_ENABLE  = 2;
    localparam int unsigned CTRL_PORT_IRQ_GLOBAL_ENABLE  = 3;
    localparam int unsigned CTRL_GIE   = 4;
    localparam int unsigned CTRL_IDLE_TIMER_PENDING = 5;

    // Status register bit positions
    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_HALT_DIS = 2;

    // Reset values
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [15:0] TIMER_RESET = 16'h0000;

    // Timing: divide by ten, 256 settling counts, bit thirteen toggle
    localparam logic [3:0]  TC_DIV           = 4'ha;
    localparam logic [15:0] SETTLE_LOAD      = 16'h0100;
    localparam logic [15:0] SETTLE_LAST      = 16'h0001;
    localparam int unsigned TIMER_TOGGLE_BIT = 13;

    // Pins able to raise the port interrupt (pins 0 to 6)
    localparam logic [7:0] IRQ_PIN_MASK = 8'h7f;

    typedef enum logic [1:0] {PSW_RUN, PSW_IDLE, PSW_HALT, PSW_SETTLE} psw_mode_t;
endpackage

/* hdl/psw_wake_if.sv */
// Carrier between the controller core and the wake edge detector
`timescale 1ns/10ps
`default_nettype none
interface psw_wake_if;
    logic [7:0] edge_sel;
    logic [7:0] pin_event;
    logic       can_event;

    modport core (output edge_sel, input pin_event, input can_event);
    modport det  (input edge_sel, output pin_event, output can_event);
endinterface
`default_nettype wire

/* hdl/psw_tick.sv */
// Instruction cycle enable: oscillator clock divided by ten
`timescale 1ns/10ps
`default_nettype none
module psw_tick
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_run,
    output logic      o_tick
);
    typedef struct packed
    {
        logic [3:0] cnt;
        logic       tick;
    } psw_tick_st_t;

    psw_tick_st_t r;
    psw_tick_st_t next_r;

    localparam logic [3:0] TC_DIV_LAST = psw_pkg::TC_DIV - 4'h1;

    // Counter stops with the oscillator, so no tick leaks out of halt
    always_comb
    begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (!i_run)
        begin
            next_r.cnt = 4'h0;
        end
        else if (r.cnt == TC_DIV_LAST)
        begin
            next_r.cnt  = 4'h0;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign o_tick = r.tick;
endmodule
`default_nettype wire

/* hdl/psw_wake_edge.sv */
// Pin synchronisers and edge detection for the wake inputs and CAN comparator
`timescale 1ns/10ps
`default_nettype none
module psw_wake_edge
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_pin,
    input  wire logic       i_can_cmp,
    psw_wake_if.det         wk
);
    typedef struct packed
    {
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic [8:0] lvl;
        logic [7:0] pin_event;
        logic       can_event;
    } psw_edge_st_t;

    psw_edge_st_t r;
    psw_edge_st_t next_r;
    logic [8:0]   new_lvl;
    logic [7:0]   sel_ev;

    // A level change counts only once stages two and three agree
    assign new_lvl = ((r.s2 ~^ r.s3) & r.s3) | (~(r.s2 ~^ r.s3) & r.lvl);

    // Per pin trigger choice: set selects falling, clear selects rising
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            assign sel_ev[gi] = wk.edge_sel[gi] ? (r.lvl[gi] & ~new_lvl[gi])
                                                : (~r.lvl[gi] & new_lvl[gi]);
        end
    endgenerate

    always_comb
    begin
        next_r           = r;
        next_r.s1        = {i_can_cmp, i_pin};
        next_r.s2        = r.s1;
        next_r.s3        = r.s2;
        next_r.lvl       = new_lvl;
        next_r.pin_event = sel_ev;
        next_r.can_event = r.lvl[8] & ~new_lvl[8];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign wk.pin_event = r.pin_event;
    assign wk.can_event = r.can_event;
endmodule
`default_nettype wire

/* hdl/psw_ctrl.sv */
// Power save mode controller with multi-input wake-up and idle timer
`timescale 1ns/10ps
`default_nettype none
module psw_ctrl
#(
    parameter bit HALT_DISABLE = 1'b0
)
(
    input  wire logic       I_CLK,
    input  wire logic       I_RST,
    input  wire logic [2:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    input  wire logic [7:0] I_WAKE_PIN,
    input  wire logic       I_CAN_RX_CMP,
    output logic            O_SYS_CLK_EN,
    output logic            O_OSC_EN,
    output logic            O_PWM_HOLD,
    output logic            O_HALTED,
    output logic            O_IDLE,
    output logic            O_PORT_IRQ,
    output logic            O_IDLE_TIMER_IRQ
);
    typedef struct packed
    {
        psw_pkg::psw_mode_t mode;
        logic               halt_request_bit;
        logic               idle_request_bit;
        logic               idle_timer_irq_enable;
        logic               port_irq_global_enable;
        logic               global_irq_enable;
        logic               idle_timer_pending;
        logic [7:0]         wake_enable_mask;
        logic [7:0]         wake_edge_select;
        logic [7:0]         wake_pending;
        logic [15:0]        idle_timer;
        logic [7:0]         rdata;
        logic               sys_clk_en;
        logic               osc_en;
        logic               pwm_hold;
        logic               halted;
        logic               idle;
        logic               port_irq;
        logic               idle_timer_irq;
    } psw_ctrl_st_t;

    psw_ctrl_st_t r;
    psw_ctrl_st_t next_r;

    psw_wake_if wk ();
    logic       tc_tick;
    logic       osc_run;

    // Edge detection on the wake pins and CAN comparator
    psw_wake_edge u_edge
    (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_pin     (I_WAKE_PIN),
        .i_can_cmp (I_CAN_RX_CMP),
        .wk        (wk.det)
    );

    // Oscillator stops in halt, so the instruction clock stops too
    assign osc_run = (r.mode != psw_pkg::PSW_HALT);

    psw_tick u_tick
    (
        .i_clk  (I_CLK),
        .i_rst  (I_RST),
        .i_run  (osc_run),
        .o_tick (tc_tick)
    );

    assign wk.edge_sel = r.wake_edge_select;

    logic wr_ctrl;
    logic wr_en;
    logic wr_edge;
    logic wr_pend;
    logic halt_blocked;
    logic timer_toggle;
    logic port_wake;
    logic [15:0] timer_dec;

    // Register write decode
    assign wr_ctrl = I_WR && (I_ADDR == psw_pkg::REG_CTRL);
    assign wr_en   = I_WR && (I_ADDR == psw_pkg::REG_WAKE_EN);
    assign wr_edge = I_WR && (I_ADDR == psw_pkg::REG_WAKE_EDGE);
    assign wr_pend = I_WR && (I_ADDR == psw_pkg::REG_WAKE_PEND);

    // Halt would wake at once, so it is refused instead
    assign halt_blocked = |(r.wake_enable_mask & r.wake_pending);

    // Idle timer counts down on each instruction cycle
    assign timer_dec = r.idle_timer - 16'h0001;

    // Bit thirteen toggle; settling reuses the timer and must not count
    assign timer_toggle = tc_tick && (r.mode != psw_pkg::PSW_SETTLE)
                          && (timer_dec[psw_pkg::TIMER_TOGGLE_BIT]
                              != r.idle_timer[psw_pkg::TIMER_TOGGLE_BIT]);

    // Enabled and pending port wake-up
    assign port_wake = |(r.wake_enable_mask & r.wake_pending);

    always_comb
    begin
        next_r       = r;
        next_r.rdata = psw_pkg::REG_RESET;

        // Register writes
        if (wr_en)
            next_r.wake_enable_mask = I_WDATA;
        if (wr_edge)
            next_r.wake_edge_select = I_WDATA;
        if (wr_pend)
            next_r.wake_pending = I_WDATA;
        // Hardware set beats a software clear in the same cycle
        next_r.wake_pending = next_r.wake_pending | wk.pin_event;

        if (wr_ctrl)
        begin
            next_r.idle_timer_irq_enable  = I_WDATA[psw_pkg::CTRL_IDLE_TIMER_IRQ_ENABLE];
            next_r.port_irq_global_enable = I_WDATA[psw_pkg::CTRL_PORT_IRQ_GLOBAL_ENABLE];
            next_r.global_irq_enable      = I_WDATA[psw_pkg::CTRL_GIE];
            next_r.idle_timer_pending     = I_WDATA[psw_pkg::CTRL_IDLE_TIMER_PENDING];
            if (I_WDATA[psw_pkg::CTRL_IDLE])
                next_r.idle_request_bit = 1'b1;
            if (I_WDATA[psw_pkg::CTRL_HALT] && !HALT_DISABLE && !halt_blocked)
                next_r.halt_request_bit = 1'b1;
        end
        if (timer_toggle)
            next_r.idle_timer_pending = 1'b1;

        // Idle timer keeps running outside halt
        if (tc_tick)
            next_r.idle_timer = timer_dec;

        // Mode sequencing
        unique case (r.mode)
            psw_pkg::PSW_RUN:
            begin
                // Halt takes priority when both are requested
                if (r.halt_request_bit)
                    next_r.mode = psw_pkg::PSW_HALT;
                else if (r.idle_request_bit)
                    next_r.mode = psw_pkg::PSW_IDLE;
            end
            psw_pkg::PSW_IDLE:
            begin
                if (port_wake || wk.can_event || timer_toggle)
                begin
                    next_r.mode             = psw_pkg::PSW_RUN;
                    next_r.idle_request_bit = 1'b0;
                end
            end
            psw_pkg::PSW_HALT:
            begin
                if (port_wake)
                begin
                    next_r.mode             = psw_pkg::PSW_SETTLE;
                    next_r.idle_timer       = psw_pkg::SETTLE_LOAD;
                    next_r.halt_request_bit = 1'b0;
                end
            end
            psw_pkg::PSW_SETTLE:
            begin
                // Clocks return only after the oscillator had time to settle
                if (tc_tick && (r.idle_timer == psw_pkg::SETTLE_LAST))
                    next_r.mode = psw_pkg::PSW_RUN;
            end
        endcase

        // Registered outputs follow the next mode
        next_r.sys_clk_en = (next_r.mode == psw_pkg::PSW_RUN);
        next_r.osc_en     = (next_r.mode != psw_pkg::PSW_HALT);
        next_r.pwm_hold   = (next_r.mode == psw_pkg::PSW_HALT)
                            || (next_r.mode == psw_pkg::PSW_SETTLE);
        next_r.halted     = (next_r.mode == psw_pkg::PSW_HALT);
        next_r.idle       = (next_r.mode == psw_pkg::PSW_IDLE);

        // Interrupt requests, pin 7 wakes but never interrupts
        next_r.port_irq = next_r.port_irq_global_enable && next_r.global_irq_enable
                          && (|(next_r.wake_enable_mask & next_r.wake_pending
                                & psw_pkg::IRQ_PIN_MASK));
        next_r.idle_timer_irq = next_r.global_irq_enable && next_r.idle_timer_irq_enable
                                && next_r.idle_timer_pending;

        // Read data stand for exactly the cycle after the strobe
        if (I_RD)
        begin
            unique case (I_ADDR)
                psw_pkg::REG_CTRL:
                begin
                    next_r.rdata[psw_pkg::CTRL_HALT]  = r.halt_request_bit;
                    next_r.rdata[psw_pkg::CTRL_IDLE]  = r.idle_request_bit;
                    next_r.rdata[psw_pkg::CTRL_IDLE_TIMER_IRQ_ENABLE]  = r.idle_timer_irq_enable;
                    next_r.rdata[psw_pkg::CTRL_PORT_IRQ_GLOBAL_ENABLE]  = r.port_irq_global_enable;
                    next_r.rdata[psw_pkg::CTRL_GIE]   = r.global_irq_enable;
                    next_r.rdata[psw_pkg::CTRL_IDLE_TIMER_PENDING] = r.idle_timer_pending;
                end
                psw_pkg::REG_WAKE_EN:   next_r.rdata = r.wake_enable_mask;
                psw_pkg::REG_WAKE_EDGE: next_r.rdata = r.wake_edge_select;
                psw_pkg::REG_WAKE_PEND: next_r.rdata = r.wake_pending;
                psw_pkg::REG_STATUS:
                begin
                    next_r.rdata[psw_pkg::STAT_MODE_LSB +: 2] = r.mode;
                    next_r.rdata[psw_pkg::STAT_HALT_DIS]      = HALT_DISABLE;
                end
                psw_pkg::REG_TIMER_LO:  next_r.rdata = r.idle_timer[7:0];
                psw_pkg::REG_TIMER_HI:  next_r.rdata = r.idle_timer[15:8];
                default:                next_r.rdata = psw_pkg::REG_RESET;
            endcase
        end
    end

    // Single state register; reset clears everything except sys_clk_en and osc_en, which it sets
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            r            <= '0;
            r.mode       <= psw_pkg::PSW_RUN;
            r.idle_timer <= psw_pkg::TIMER_RESET;
            r.sys_clk_en <= 1'b1;
            r.osc_en     <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign O_RDATA          = r.rdata;
    assign O_SYS_CLK_EN     = r.sys_clk_en;
    assign O_OSC_EN         = r.osc_en;
    assign O_PWM_HOLD       = r.pwm_hold;
    assign O_HALTED         = r.halted;
    assign O_IDLE           = r.idle;
    assign O_PORT_IRQ       = r.port_irq;
    assign O_IDLE_TIMER_IRQ = r.idle_timer_irq;
endmodule
`default_nettype wire

/* test/psw_ctrl_asserts.sv */
// Port-level checker for the power save controller
`timescale 1ns/10ps
`default_nettype none
module psw_ctrl_asserts
#(
    parameter bit HALT_DISABLE = 1'b0
)
(
    input wire logic       I_CLK,
    input wire logic       I_RST,
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic       I_WR,
    input wire logic       I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic [7:0] I_WAKE_PIN,
    input wire logic       I_CAN_RX_CMP,
    input wire logic       O_SYS_CLK_EN,
    input wire logic       O_OSC_EN,
    input wire logic       O_PWM_HOLD,
    input wire logic       O_HALTED,
    input wire logic       O_IDLE,
    input wire logic       O_PORT_IRQ,
    input wire logic       O_IDLE_TIMER_IRQ
);
    logic [15:0] settle_len;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    // Cycles spent in settle; too long a count would unroll badly
    always_ff @(posedge I_CLK)
    begin
        if (I_RST || !O_PWM_HOLD || O_HALTED)
            settle_len <= 16'h0000;
        else
            settle_len <= settle_len + 16'h0001;
    end

    AST_HALT_STOP: assert property (O_HALTED |-> !O_OSC_EN && !O_SYS_CLK_EN && O_PWM_HOLD)
        else $error("halt outputs wrong");
    AST_HALT_CAUSE: assert property ($rose(O_HALTED) |-> $past(I_WR, 2) &&
        $past(I_ADDR, 2) == psw_pkg::REG_CTRL && ($past(I_WDATA, 2) & 8'h01) != 8'h00)
        else $error("halt without request");
    AST_SETTLE_OPEN: assert property ($fell(O_HALTED) |-> O_OSC_EN && O_PWM_HOLD && !O_SYS_CLK_EN)
        else $error("settle outputs wrong");
    AST_SETTLE_LEN: assert property ($fell(O_PWM_HOLD) && !O_HALTED |-> settle_len inside {[2540:2580]})
        else $error("settle length wrong");
    AST_IDLE_RUN: assert property (O_IDLE |-> O_OSC_EN && !O_SYS_CLK_EN && !O_PWM_HOLD)
        else $error("idle outputs wrong");
    AST_HALT_OFF: assert property (HALT_DISABLE |-> !O_HALTED)
        else $error("halt despite disable");
    AST_HALT_HOLD: assert property ((O_HALTED && $stable(I_WAKE_PIN) && !I_WR) [*8] |=> O_HALTED)
        else $error("halt left without wake");
    AST_CAN_WAKE: assert property (O_IDLE && $fell(I_CAN_RX_CMP) |-> ##[1:8] !O_IDLE)
        else $error("idle kept after CAN edge");
    AST_RDATA_SLOT: assert property (O_RDATA != 8'h00 |-> $past(I_RD))
        else $error("read data outside slot");
endmodule

bind psw_ctrl psw_ctrl_asserts #(.HALT_DISABLE(HALT_DISABLE)) u_asserts (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_WAKE_PIN(I_WAKE_PIN),
    .I_CAN_RX_CMP(I_CAN_RX_CMP), .O_SYS_CLK_EN(O_SYS_CLK_EN), .O_OSC_EN(O_OSC_EN), .O_PWM_HOLD(O_PWM_HOLD),
    .O_HALTED(O_HALTED), .O_IDLE(O_IDLE), .O_PORT_IRQ(O_PORT_IRQ), .O_IDLE_TIMER_IRQ(O_IDLE_TIMER_IRQ));
`default_nettype wire

/* test/psw_ctrl_tb.sv */
// Self-checking bench for the power save controller
`timescale 1ns/10ps
`default_nettype none
module psw_ctrl_tb;
    logic       I_CLK = 1'b0;
    logic       I_RST = 1'b1;
    logic [2:0] I_ADDR = 3'h0;
    logic [7:0] I_WDATA = 8'h00;
    logic       I_WR = 1'b0;
    logic       I_RD = 1'b0;
    logic [7:0] I_WAKE_PIN = 8'h00;
    logic       I_CAN_RX_CMP = 1'b1;
    logic [7:0] o_rdata;
    logic       o_sys_clk_en, o_osc_en, o_pwm_hold, o_halted, o_idle, o_port_irq, o_t0_irq, o_halted_hd;
    logic       rd_flag = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    int         bad_count = 0;
    int         compares = 0;
    int         n;

    always #4 I_CLK = ~I_CLK;

    psw_ctrl u_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .O_RDATA(o_rdata), .I_WAKE_PIN(I_WAKE_PIN), .I_CAN_RX_CMP(I_CAN_RX_CMP),
        .O_SYS_CLK_EN(o_sys_clk_en), .O_OSC_EN(o_osc_en), .O_PWM_HOLD(o_pwm_hold), .O_HALTED(o_halted),
        .O_IDLE(o_idle), .O_PORT_IRQ(o_port_irq), .O_IDLE_TIMER_IRQ(o_t0_irq));
    // Copy built with halt disabled, fed the same stimulus
    psw_ctrl #(.HALT_DISABLE(1'b1)) u_dut_hd (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(), .I_WAKE_PIN(I_WAKE_PIN), .I_CAN_RX_CMP(I_CAN_RX_CMP),
        .O_SYS_CLK_EN(), .O_OSC_EN(), .O_PWM_HOLD(), .O_HALTED(o_halted_hd), .O_IDLE(), .O_PORT_IRQ(),
        .O_IDLE_TIMER_IRQ());

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Strobes drop one edge before the next cycle may raise them
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        I_WR    <= 1'b1;
        I_ADDR  <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
        @(posedge I_CLK);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        I_RD   <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        @(posedge I_CLK);
    endtask

    // Bounded wait: 0 halt ends, 1 clocks back, 2 idle ends
    task automatic wait_on(input int sel, input int lim, output int cyc);
        logic hit;
        for (cyc = 0; cyc < lim; cyc++)
        begin
            @(negedge I_CLK);
            hit = (sel == 0) ? !o_halted : (sel == 1) ? o_sys_clk_en : !o_idle;
            if (hit === 1'b1)
                break;
        end
        if (cyc == lim)
        begin
            bad_count++;
            $display("[ERR] wait %0d expected done seen timeout", sel);
            end_sim();
        end
        else
            @(posedge I_CLK);
    endtask

    // Read data stand one cycle only, so compare mid-cycle
    always @(posedge I_CLK) rd_flag <= I_RD;
    always @(negedge I_CLK)
    begin
        if (rd_flag === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("read queue", 8'h00, 8'hff);
            else
                chk("read data", exp_q.pop_front(), o_rdata);
        end
    end

    initial
    begin
        void'($urandom(66));
        repeat (3) @(posedge I_CLK);
        I_RST <= 1'b0;
        @(posedge I_CLK);
        // Reset values, random read back, unmapped slot
        for (n = 0; n < 5; n++)
            rd(3'(n), 8'h00);
        for (n = 1; n < 4; n++)
        begin
            v = 8'($urandom);
            wr(3'(n), v);
            rd(3'(n), v);
            wr(3'(n), 8'h00);
        end
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        $display("test 1 registers done");
        // Selected edges latch, unselected do not
        v = 8'($urandom);
        wr(psw_pkg::REG_WAKE_EDGE, v);
        I_WAKE_PIN <= v;
        repeat (8) @(posedge I_CLK);
        rd(psw_pkg::REG_WAKE_PEND, 8'h00);
        I_WAKE_PIN <= ~v;
        repeat (8) @(posedge I_CLK);
        rd(psw_pkg::REG_WAKE_PEND, 8'hff);
        I_WAKE_PIN <= v;
        repeat (40) @(posedge I_CLK);
        rd(psw_pkg::REG_WAKE_PEND, 8'hff);
        wr(psw_pkg::REG_WAKE_EN, 8'hff);
        wr(psw_pkg::REG_CTRL, 8'h08);
        chk("port irq", 8'h00, {7'h00, o_port_irq});
        wr(psw_pkg::REG_CTRL, 8'h18);
        chk("port irq", 8'h01, {7'h00, o_port_irq});
        wr(psw_pkg::REG_WAKE_PEND, 8'h80);
        chk("port irq", 8'h00, {7'h00, o_port_irq});
        wr(psw_pkg::REG_CTRL, 8'h34);
        chk("timer irq", 8'h01, {7'h00, o_t0_irq});
        wr(psw_pkg::REG_CTRL, 8'h30);
        chk("timer irq", 8'h00, {7'h00, o_t0_irq});
        wr(psw_pkg::REG_CTRL, 8'h00);
        $display("test 2 edges done");
        // Halt refused while enabled and pending
        wr(psw_pkg::REG_WAKE_EN, 8'h01);
        wr(psw_pkg::REG_WAKE_PEND, 8'h01);
        wr(psw_pkg::REG_CTRL, 8'h01);
        rd(psw_pkg::REG_STATUS, 8'h00);
        rd(psw_pkg::REG_CTRL, 8'h00);
        // Halt, ignore a masked pin, wake on pin 0, settle
        wr(psw_pkg::REG_WAKE_EN, 8'h00);
        wr(psw_pkg::REG_WAKE_EDGE, 8'h00);
        I_WAKE_PIN <= 8'h00;
        repeat (8) @(posedge I_CLK);
        wr(psw_pkg::REG_WAKE_PEND, 8'h00);
        wr(psw_pkg::REG_WAKE_EN, 8'h01);
        wr(psw_pkg::REG_CTRL, 8'h01);
        I_WAKE_PIN <= 8'h02;
        repeat (20) @(posedge I_CLK);
        rd(psw_pkg::REG_STATUS, 8'h02);
        chk("halt disabled copy", 8'h00, {7'h00, o_halted_hd});
        I_WAKE_PIN <= 8'h03;
        wait_on(0, 20, n);
        wait_on(1, 3000, n);
        chk("settle window", 8'h01, {7'h00, n >= 2540 && n <= 2580});
        rd(psw_pkg::REG_CTRL, 8'h00);
        rd(psw_pkg::REG_WAKE_PEND, 8'h03);
        // Reset ends a second halt
        wr(psw_pkg::REG_WAKE_PEND, 8'h00);
        wr(psw_pkg::REG_CTRL, 8'h01);
        repeat (5) @(posedge I_CLK);
        rd(psw_pkg::REG_STATUS, 8'h02);
        I_RST <= 1'b1;
        repeat (3) @(posedge I_CLK);
        I_RST <= 1'b0;
        @(posedge I_CLK);
        rd(psw_pkg::REG_STATUS, 8'h00);
        rd(psw_pkg::REG_CTRL, 8'h00);
        rd(psw_pkg::REG_WAKE_EN, 8'h00);
        $display("test 3 halt done");
        // Idle, left by a CAN edge, then by pin 1 falling
        repeat (8) @(posedge I_CLK);
        wr(psw_pkg::REG_WAKE_PEND, 8'h00);
        wr(psw_pkg::REG_CTRL, 8'h02);
        repeat (4) @(posedge I_CLK);
        rd(psw_pkg::REG_STATUS, 8'h01);
        I_CAN_RX_CMP <= 1'b0;
        wait_on(2, 20, n);
        rd(psw_pkg::REG_CTRL, 8'h00);
        rd(psw_pkg::REG_WAKE_PEND, 8'h00);
        I_CAN_RX_CMP <= 1'b1;
        wr(psw_pkg::REG_WAKE_EDGE, 8'h02);
        wr(psw_pkg::REG_WAKE_EN, 8'h02);
        wr(psw_pkg::REG_CTRL, 8'h02);
        repeat (4) @(posedge I_CLK);
        rd(psw_pkg::REG_STATUS, 8'h01);
        I_WAKE_PIN <= 8'h01;
        wait_on(2, 20, n);
        rd(psw_pkg::REG_WAKE_PEND, 8'h02);
        rd(psw_pkg::REG_STATUS, 8'h00);
        $display("test 4 idle done");
        end_sim();
    end
endmodule
`default_nettype wire
